// ===== common/plsr_pkg.sv
// plsr_pkg: constants shared by the parallel-load shift register and its buffer.
// assumes one 100 MHz system clock; all pin inputs are asynchronous to it.
package plsr_pkg;
   // chain geometry
   localparam int unsigned STAGES      = 8;
   localparam int unsigned LAST_STAGE  = STAGES - 1;
   // input synchroniser depth
   localparam int unsigned SYNC_DEPTH  = 2;
   // shifted-bit buffer geometry
   localparam int unsigned BUF_WIDTH   = 1;
   localparam int unsigned BUF_DEPTH   = 2;
   // system clock
   localparam int unsigned CLK_PERIOD_NS = 10;
   // reset values of control flops
   localparam logic [1:0] RST_SYNC_RESET  = 2'h0;
   localparam logic       GATE_PREV_RESET = 1'h1; // no false edge after reset
   localparam logic       SEEN_RESET      = 1'h0;
endpackage

// ===== hw/plsr_bit_buffer.sv
// plsr_bit_buffer: two-entry buffer with valid and ready on both sides.
// assumes a synchronised active-low reset copy from the top module.
`timescale 1ns/1ps
module plsr_bit_buffer #(
   parameter int unsigned WIDTH = plsr_pkg::BUF_WIDTH
) (
   // clock and reset
   input  wire logic             sys_clk,
   input  wire logic             rst_sync_b,
   // filling side
   input  wire logic             in_valid,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  in_ready,
   // draining side
   output logic                  out_valid,
   output logic      [WIDTH-1:0] out_data,
   input  wire logic             out_ready
);
   import plsr_pkg::*;

   logic             spare_valid;
   logic [WIDTH-1:0] spare_data;
   logic             next_out_valid;
   logic             next_spare_valid;
   logic             push;
   logic             pop;

   assign push = in_valid & in_ready;
   assign pop  = out_valid & out_ready;

   // head slot refills from the spare slot first so order is kept
   always_comb begin
      next_out_valid   = out_valid;
      next_spare_valid = spare_valid;
      if (!out_valid || pop) begin
         next_out_valid   = spare_valid | push;
         next_spare_valid = spare_valid & push;
      end else if (push) begin
         next_spare_valid = 1'h1;
      end
   end

   // valid flags and registered ready, so ready is an honest not-full
   always_ff @(posedge sys_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         out_valid   <= 1'h0;
         spare_valid <= 1'h0;
         in_ready    <= 1'h0;
      end else begin
         out_valid   <= next_out_valid;
         spare_valid <= next_spare_valid;
         in_ready    <= ~next_spare_valid;
      end
   end

   // data slots carry no reset; they are qualified by the valid flags
   always_ff @(posedge sys_clk) begin
      if (!out_valid || pop) begin
         if (spare_valid) begin
            out_data <= spare_data;
         end else begin
            out_data <= in_data;
         end
         if (spare_valid && push) begin
            spare_data <= in_data;
         end
      end else if (push) begin
         spare_data <= in_data;
      end
   end
endmodule // plsr_bit_buffer

// ===== hw/plsr_shift_register.sv
// plsr_shift_register: eight-stage parallel/serial-in, serial-out shift register.
// assumes all control and data pins are asynchronous; they pass two flops first.
// Function
// - eight storage stages, filled in parallel or serially, emptied serially
// - load low makes every stage copy its parallel input, ignoring clocks
// - during load, true output follows last parallel input, inverted output opposite
// - load high and no qualifying edge: stages keep their contents
// - qualifying rising edge: serial input enters first stage, others move on
// - last stage value is discarded on each shift
// - true output equals last stage, inverted output its complement
// - no shift while inhibit high, nor while clock high
// - clock and inhibit interchangeable; either rising, other low, shifts once
// - stages have no reset; contents unknown until written
`timescale 1ns/1ps
module plsr_shift_register (
   // clock and reset
   input  wire logic                          sys_clk,
   input  wire logic                          rst_b,
   // register pins
   input  wire logic                          shift_not_load,
   input  wire logic                          shift_clock,
   input  wire logic                          clock_inhibit,
   input  wire logic                          serial_in,
   input  wire logic [plsr_pkg::STAGES-1:0]   parallel_inputs,
   output logic                               serial_out,
   output logic                               serial_out_n,
   // stream of bits shifted out of the last stage
   output logic                               bit_valid,
   output logic                               bit_data,
   input  wire logic                          bit_ready,
   output logic                               fill_ready
);
   import plsr_pkg::*;

   logic [1:0]          rst_sync;
   logic                rst_sync_b;
   logic [STAGES+3:0]   pin_meta;
   logic [STAGES+3:0]   pin_sync;
   logic                snl_s;
   logic                clk_s;
   logic                inh_s;
   logic                ser_s;
   logic [STAGES-1:0]   par_s;
   logic                gate_now;
   logic                gate_prev;
   logic                shift_evt;
   logic [STAGES-1:0]   stage;
   logic [STAGES-1:0]   next_stage;
   logic                seen_load;

   // reset release through two flops; assertion is immediate
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_sync <= RST_SYNC_RESET;
      end else begin
         rst_sync <= {rst_sync[0], 1'h1};
      end
   end
   assign rst_sync_b = rst_sync[1];

   // two-flop synchronisers for every pin; first rank read only by the second
   always_ff @(posedge sys_clk) begin
      pin_meta <= {shift_not_load, shift_clock, clock_inhibit, serial_in, parallel_inputs};
      pin_sync <= pin_meta;
   end
   assign {snl_s, clk_s, inh_s, ser_s, par_s} = pin_sync;

   // or-gated clock
   // either input rising while the other is low gives one rising edge here
   assign gate_now = clk_s | inh_s;

   always_ff @(posedge sys_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         gate_prev <= GATE_PREV_RESET;
      end else begin
         gate_prev <= gate_now;
      end
   end

   // edge qualification
   // a high level on either input holds the gate high, so no edge can form
   assign shift_evt = snl_s & gate_now & ~gate_prev;

   // next chain value
   // the load is level driven, emulated by copying the pins every cycle
   genvar gi;
   generate
      for (gi = 0; gi < STAGES; gi++) begin : g_stage
         if (gi == 0) begin : g_first
            always_comb begin
               if (!snl_s) begin
                  next_stage[gi] = par_s[gi];
               end else if (shift_evt) begin
                  next_stage[gi] = ser_s;
               end else begin
                  next_stage[gi] = stage[gi];
               end
            end
         end else begin : g_rest
            always_comb begin
               if (!snl_s) begin
                  next_stage[gi] = par_s[gi];
               end else if (shift_evt) begin
                  next_stage[gi] = stage[gi-1];
               end else begin
                  next_stage[gi] = stage[gi];
               end
            end
         end
      end
   endgenerate

   // last value dropped; only copy leaves through the bit stream
   always_ff @(posedge sys_clk) begin
      stage <= next_stage;
   end

   // output pair
   // both outputs are flops fed from the same next value, so they never skew
   always_ff @(posedge sys_clk) begin
      serial_out   <= next_stage[LAST_STAGE];
      serial_out_n <= ~next_stage[LAST_STAGE];
   end

   // marks that the chain holds defined data, for the checks below
   always_ff @(posedge sys_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         seen_load <= SEEN_RESET;
      end else if (!snl_s) begin
         seen_load <= 1'h1;
      end
   end

   // shifted-out bits are buffered; a full buffer drops the bit and fill_ready shows it
   plsr_bit_buffer #(
      .WIDTH (BUF_WIDTH)
   ) u_buffer (
      .sys_clk    (sys_clk),
      .rst_sync_b (rst_sync_b),
      .in_valid   (shift_evt),
      .in_data    (stage[LAST_STAGE]),
      .in_ready   (fill_ready),
      .out_valid  (bit_valid),
      .out_data   (bit_data),
      .out_ready  (bit_ready)
   );

   property p_load_copies;
      @(posedge sys_clk) disable iff (!rst_sync_b)
      !snl_s |=> stage == $past(par_s);
   endproperty
   a_load_copies: assert property (p_load_copies)
      else $error("stages did not take parallel inputs during load");

   property p_load_output;
      @(posedge sys_clk) disable iff (!rst_sync_b)
      !snl_s |=> (serial_out == $past(par_s[LAST_STAGE]))
                 && (serial_out_n != $past(par_s[LAST_STAGE]));
   endproperty
   a_load_output: assert property (p_load_output)
      else $error("outputs do not follow last parallel input during load");

   property p_hold;
      @(posedge sys_clk) disable iff (!rst_sync_b)
      seen_load && snl_s && !shift_evt |=> $stable(stage);
   endproperty
   a_hold: assert property (p_hold)
      else $error("stages changed without a qualifying edge");

   property p_shift;
      @(posedge sys_clk) disable iff (!rst_sync_b)
      seen_load && shift_evt |=> (stage[0] == $past(ser_s))
                                 && (stage[STAGES-1:1] == $past(stage[STAGES-2:0]));
   endproperty
   a_shift: assert property (p_shift)
      else $error("shift did not move the chain by one place");

   property p_discard;
      @(posedge sys_clk) disable iff (!rst_sync_b)
      seen_load && snl_s && shift_evt |=> serial_out == $past(stage[LAST_STAGE-1]);
   endproperty
   a_discard: assert property (p_discard)
      else $error("last stage not replaced by its neighbour on shift");

   property p_outputs;
      @(posedge sys_clk) disable iff (!rst_sync_b)
      seen_load |-> (serial_out == stage[LAST_STAGE]) && (serial_out_n != serial_out);
   endproperty
   a_outputs: assert property (p_outputs)
      else $error("outputs disagree with last stage");

   property p_blocked;
      @(posedge sys_clk) disable iff (!rst_sync_b)
      $past(clk_s) || $past(inh_s) |-> !shift_evt;
   endproperty
   a_blocked: assert property (p_blocked)
      else $error("shift taken while clock or inhibit was high");

   property p_either_edge;
      @(posedge sys_clk) disable iff (!rst_sync_b)
      snl_s && (($rose(clk_s) && !inh_s && !$past(inh_s))
                || ($rose(inh_s) && !clk_s && !$past(clk_s))) |-> shift_evt;
   endproperty
   a_either_edge: assert property (p_either_edge)
      else $error("rising edge on clock or inhibit gave no shift");

   property p_push_stream;
      @(posedge sys_clk) disable iff (!rst_sync_b)
      seen_load && shift_evt && fill_ready && !bit_valid |=> bit_valid
         && (bit_data == $past(stage[LAST_STAGE]));
   endproperty
   a_push_stream: assert property (p_push_stream)
      else $error("shifted-out bit not presented on the stream");
endmodule // plsr_shift_register

// ===== bench/plsr_ctrl_model.sv
// plsr_ctrl_model: controller that loads the register and reads its bits serially.
// assumes a free-running sys_clk; go is a one-cycle request from the bench.
`timescale 1ns/1ps
module plsr_ctrl_model (
   // clock and request
   input  wire logic       sys_clk,
   input  wire logic       go,
   input  wire logic       skip_load,
   input  wire logic [1:0] mode,
   // register pins
   input  wire logic       serial_out,
   output logic            shift_not_load,
   output logic            shift_clock,
   output logic            clock_inhibit,
   // result
   output logic [7:0]      rd_byte,
   output logic            done
);
   logic [7:0] acc;
   task automatic wait_n(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   // levels held four cycles, longer than the two-flop input path needs
   initial begin
      {shift_clock, clock_inhibit, done, rd_byte, acc} = '0;
      shift_not_load = 1'b1;
      forever begin
         @(posedge sys_clk);
         done <= 1'b0;
         if (go) begin
            shift_not_load <= skip_load;
            // modes 2 and 3 raise the other line while edges are ignored
            shift_clock    <= (mode == 2'h3);
            clock_inhibit  <= (mode == 2'h2);
            wait_n(4);
            shift_not_load <= 1'b1;
            wait_n(4);
            acc = {7'h0, serial_out};
            repeat (7) begin
               if (mode[0]) clock_inhibit <= 1'b1;
               else shift_clock <= 1'b1;
               wait_n(4);
               if (mode[0]) clock_inhibit <= 1'b0;
               else shift_clock <= 1'b0;
               wait_n(4);
               acc = {acc[6:0], serial_out};
            end
            // lines rest low between frames
            shift_clock   <= 1'b0;
            clock_inhibit <= 1'b0;
            wait_n(4);
            rd_byte <= acc;
            done    <= 1'b1;
         end
      end
   end
endmodule // plsr_ctrl_model

// ===== bench/tb_parallel_load_shift_register.sv
// tb_parallel_load_shift_register: reads random bytes in every clocking mode.
// assumes the controller model drives the control pins; bench drives data pins.
`timescale 1ns/1ps
module tb_parallel_load_shift_register;
   import plsr_pkg::*;
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
   $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
   logic              sys_clk, rst_b, serial_in, bit_ready, go, skip_load, loaded;
   logic              shift_not_load, shift_clock, clock_inhibit, serial_out, serial_out_n;
   logic              bit_valid, bit_data, fill_ready, done, eb;
   logic [1:0]        mode;
   logic [STAGES-1:0] parallel_inputs, rd_byte, stg, ey;
   logic              q_bit[$];
   logic [7:0]        q_byte[$];
   int                n_errors, n_checks, seed;

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   plsr_shift_register dut (.sys_clk(sys_clk), .rst_b(rst_b),
      .shift_not_load(shift_not_load), .shift_clock(shift_clock),
      .clock_inhibit(clock_inhibit), .serial_in(serial_in),
      .parallel_inputs(parallel_inputs), .serial_out(serial_out),
      .serial_out_n(serial_out_n), .bit_valid(bit_valid), .bit_data(bit_data),
      .bit_ready(bit_ready), .fill_ready(fill_ready));

   plsr_ctrl_model ctrl (.sys_clk(sys_clk), .go(go), .skip_load(skip_load), .mode(mode),
      .serial_out(serial_out), .shift_not_load(shift_not_load),
      .shift_clock(shift_clock), .clock_inhibit(clock_inhibit),
      .rd_byte(rd_byte), .done(done));

   task automatic wrap_up;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // one frame; stall drops every bit after the two the buffer holds
   task automatic read_reg(input logic [1:0] m, input logic skip);
      logic       s;
      logic [7:0] p, e;
      int         k;
      s = 1'($random(seed));
      p = 8'($random(seed));
      if (!skip) stg = p;
      parallel_inputs <= p;
      serial_in       <= s;
      mode            <= m;
      skip_load       <= skip;
      go              <= 1'b1;
      @(posedge sys_clk);
      go <= 1'b0;
      // with no load pending, raising the held line is itself one shift
      if (m[1] && skip) begin
         q_bit.push_back(stg[7]);
         stg = {stg[6:0], s};
      end
      e = {8{stg[7]}};
      // otherwise modes 2 and 3 shift nothing
      if (!m[1]) for (k = 0; k < 7; k++) begin
         if (bit_ready || k < 2) q_bit.push_back(stg[7]);
         stg = {stg[6:0], s};
         e   = {e[6:0], stg[7]};
      end
      q_byte.push_back(e);
      for (k = 0; k < 200 && done !== 1'b1; k++) @(posedge sys_clk);
      if (done !== 1'b1) begin
         n_errors++;
         wrap_up();
      end
      loaded = 1'b1;
      $display("test mode %0d skip %0d finished", m, skip);
   endtask

   // result watcher: oldest note against each result
   always @(posedge sys_clk) begin
      if (done === 1'b1) begin
         ey = q_byte.pop_front();
         `CHK("rd_byte", ey, rd_byte)
      end
      if (rst_b && bit_valid === 1'b1 && bit_ready === 1'b1) begin
         eb = (q_bit.size() > 0) ? q_bit.pop_front() : 1'bx;
         `CHK("bit_data", eb, bit_data)
      end
      if (loaded) `CHK("serial_out_n", 1'b1, serial_out ^ serial_out_n)
   end

   initial begin
      seed = 32'hdb96;
      {rst_b, serial_in, go, skip_load, loaded, mode, parallel_inputs, stg} = '0;
      bit_ready = 1'b1;
      n_errors  = 0;
      n_checks  = 0;
      repeat (6) @(posedge sys_clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge sys_clk);
      for (int m = 0; m < 4; m++) read_reg(2'(m), 1'b0);
      // serial input reaches the output after the parallel bits
      read_reg(2'h0, 1'b1);
      read_reg(2'h1, 1'b1);
      read_reg(2'h3, 1'b1);
      // receiver stalls through a whole frame, then drains
      bit_ready <= 1'b0;
      @(posedge sys_clk);
      read_reg(2'h0, 1'b0);
      `CHK("fill_ready", 1'b0, fill_ready)
      bit_ready <= 1'b1;
      repeat (5) @(posedge sys_clk);
      `CHK("bit_valid", 1'b0, bit_valid)
      `CHK("fill_ready", 1'b1, fill_ready)
      repeat (6) read_reg(2'($random(seed)), 1'($random(seed)));
      repeat (5) @(posedge sys_clk);
      `CHK("leftover", 0, q_bit.size() + q_byte.size())
      wrap_up();
   end
endmodule // tb_parallel_load_shift_register
